// ===== core/iopm_core.v
// Contract
// - line 0 takes codes 0,2,3,4,5 only; code 1 unused
// - line 1 takes 0-5; code 1 drives serial attention on through-hole
// - line 2 takes 0-5; code 1 is serial clock on through-hole
// - line 3 takes 0-5; code 1 is serial select on through-hole
// - line 4 takes 0,1,3,4,5; code 1 is serial data in on through-hole
// - line 5 takes 0,1,3,4,5; code 1, default, blinks while associated
// - sleep line takes 0 or 3; always controls pin sleep
// - pwm0 pin takes 0-2; default is signal-strength output
// - matching source and pwm0 plain mode: channel zero samples update duty0
// - matching source and pwm1 mode: channel zero samples update duty1
// - pwm1 pin takes 0 or 2; default disabled
// - pwm period 64 us in 1023 steps; duty 0 off, 0x3ff full
// - through-hole miso enable takes 0 or 1, default 0
// - surface-mount serial pin enables take 0 or 1, default 1
// - pull enable mask bit 1 enables pull on its line, default 0xff
// - mask bits: 0 line4, 1-4 lines 3..0, 5 line6, 6 sleep, 7 data in
// - pull direction mask uses same mapping, default 0xff
// - masks read with bit 0 as least significant
// - rssi pwm updates per packet, stops on timer; 0xff always on
// - pwm reverts to configured duty after timeout; 0 never reverts
// - all-ones address disables passing; 0xffff accepts any source
`timescale 1ns/1ps
`include "iopm_regs.vh"
module iopm_core #(
  parameter TICK_CYC = `IOPM_TICK_NS / `IOPM_CLK_NS,
  parameter BLINK_CYC = `IOPM_BLINK_NS / `IOPM_CLK_NS
) (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // command port
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [4:0] cmd_sel_i,
  input wire [15:0] cmd_wdata_i,
  input wire cmd_apply_i,
  output reg cmd_ack_o,
  output reg cmd_err_o,
  output reg [15:0] cmd_rdata_o,
  // straps and pins
  input wire variant_sm_i,
  input wire sleep_req_i,
  // device status
  input wire assoc_i,
  input wire attn_i,
  input wire rx_pkt_i,
  input wire [7:0] rx_rssi_i,
  input wire sample_valid_i,
  input wire [63:0] sample_src_i,
  input wire [9:0] sample_ad0_i,
  // general lines
  output reg [5:0] line_oe_o,
  output reg [5:0] line_out_o,
  output reg [5:0] line_din_en_o,
  output reg [3:0] line_adc_en_o,
  output reg sleep_din_en_o,
  output reg pin_sleep_o,
  // serial peripheral pin enables
  output reg spi_miso_en_o,
  output reg spi_mosi_en_o,
  output reg spi_ssel_en_o,
  output reg spi_sclk_en_o,
  output reg serial_attention_out_en_o,
  // pull resistors
  output reg [7:0] pull_en_o,
  output reg [7:0] pull_up_o,
  // pwm
  output reg pwm0_o,
  output reg pwm1_o
);

  localparam integer PWM_CYC = `IOPM_PWM_PERIOD_NS / `IOPM_CLK_NS;

  reg [15:0] pend_ff [0:`IOPM_NUM_SEL-1];
  reg [15:0] act_ff [0:`IOPM_NUM_SEL-1];
  reg [1:0] sm_sync_ff;
  reg [1:0] slp_sync_ff;
  reg [31:0] tick_cnt_ff;
  reg tick_ff;
  reg [31:0] blink_cnt_ff;
  reg blink_ff;
  reg [9:0] pwm_cnt_ff;
  reg [9:0] duty0_ff;
  reg [9:0] duty1_ff;
  reg [7:0] rssi_cnt_ff;
  reg rssi_on_ff;
  reg [7:0] rev0_cnt_ff;
  reg [7:0] rev1_cnt_ff;
  integer i;

  // reset value of each setting
  function [15:0] rst_val;
    input [4:0] sel;
    begin
      case (sel)
        `IOPM_SEL_DIO5: rst_val = `IOPM_RST_DIO5;
        `IOPM_SEL_PWM0_FN: rst_val = `IOPM_RST_PWM0_FN;
        `IOPM_SEL_MISO_SM, `IOPM_SEL_MOSI_SM, `IOPM_SEL_SSEL_SM,
        `IOPM_SEL_SCLK_SM, `IOPM_SEL_ATTN_SM: rst_val = `IOPM_RST_SM_PIN;
        `IOPM_SEL_PULL_EN, `IOPM_SEL_PULL_DIR: rst_val = `IOPM_RST_PULL;
        `IOPM_SEL_RSSI_TMR: rst_val = `IOPM_RST_RSSI_TMR;
        `IOPM_SEL_PWM_TMO: rst_val = `IOPM_RST_PWM_TMO;
        `IOPM_SEL_ADDR0, 5'h16, 5'h17, `IOPM_SEL_ADDR3: rst_val = `IOPM_RST_ADDR;
        default: rst_val = `IOPM_RST_ZERO;
      endcase
    end
  endfunction

  // legal value check per setting
  function legal;
    input [4:0] sel;
    input [15:0] d;
    begin
      case (sel)
        `IOPM_SEL_DIO0: legal = (d <= 16'h0005) && (d != 16'h0001);
        `IOPM_SEL_DIO1, `IOPM_SEL_DIO2, `IOPM_SEL_DIO3: legal = (d <= 16'h0005);
        `IOPM_SEL_DIO4, `IOPM_SEL_DIO5: legal = (d <= 16'h0005) && (d != 16'h0002);
        `IOPM_SEL_SLEEP: legal = (d == 16'h0000) || (d == 16'h0003);
        `IOPM_SEL_PWM0_FN: legal = (d <= 16'h0002);
        `IOPM_SEL_PWM1_FN: legal = (d == 16'h0000) || (d == 16'h0002);
        `IOPM_SEL_MISO_TH, `IOPM_SEL_MISO_SM, `IOPM_SEL_MOSI_SM,
        `IOPM_SEL_SSEL_SM, `IOPM_SEL_SCLK_SM, `IOPM_SEL_ATTN_SM: legal = (d <= 16'h0001);
        `IOPM_SEL_DUTY0, `IOPM_SEL_DUTY1: legal = (d <= 16'h03ff);
        `IOPM_SEL_PULL_EN, `IOPM_SEL_PULL_DIR,
        `IOPM_SEL_RSSI_TMR, `IOPM_SEL_PWM_TMO: legal = (d <= 16'h00ff);
        `IOPM_SEL_ADDR0, 5'h16, 5'h17, `IOPM_SEL_ADDR3: legal = 1'b1;
        default: legal = 1'b0;
      endcase
    end
  endfunction

  // active settings as named fields
  wire [2:0] fn0 = act_ff[`IOPM_SEL_DIO0][2:0];
  wire [2:0] fn1 = act_ff[`IOPM_SEL_DIO1][2:0];
  wire [2:0] fn2 = act_ff[`IOPM_SEL_DIO2][2:0];
  wire [2:0] fn3 = act_ff[`IOPM_SEL_DIO3][2:0];
  wire [2:0] fn4 = act_ff[`IOPM_SEL_DIO4][2:0];
  wire [2:0] fn5 = act_ff[`IOPM_SEL_DIO5][2:0];
  wire [2:0] fn_slp = act_ff[`IOPM_SEL_SLEEP][2:0];
  wire [1:0] pfn0 = act_ff[`IOPM_SEL_PWM0_FN][1:0];
  wire [1:0] pfn1 = act_ff[`IOPM_SEL_PWM1_FN][1:0];
  wire [9:0] cfg_duty0 = act_ff[`IOPM_SEL_DUTY0][9:0];
  wire [9:0] cfg_duty1 = act_ff[`IOPM_SEL_DUTY1][9:0];
  wire [7:0] rssi_tmr = act_ff[`IOPM_SEL_RSSI_TMR][7:0];
  wire [7:0] pwm_tmo = act_ff[`IOPM_SEL_PWM_TMO][7:0];
  wire [63:0] src_addr = {act_ff[`IOPM_SEL_ADDR3], act_ff[5'h17], act_ff[5'h16], act_ff[`IOPM_SEL_ADDR0]};
  wire is_sm = sm_sync_ff[1];
  wire is_th = ~sm_sync_ff[1];

  // command port and settings store
  wire cmd_ok = legal(cmd_sel_i, cmd_wdata_i);
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (i = 0; i < `IOPM_NUM_SEL; i = i + 1) begin
        pend_ff[i] <= rst_val(i[4:0]);
        act_ff[i] <= rst_val(i[4:0]);
      end
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      cmd_rdata_o <= 16'h0000;
    end else begin
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      if (cmd_valid_i) begin
        cmd_ack_o <= 1'b1;
        if (cmd_sel_i >= `IOPM_NUM_SEL) begin
          cmd_err_o <= 1'b1;
          cmd_rdata_o <= 16'h0000;
        end else if (cmd_write_i) begin
          if (cmd_ok)
            pend_ff[cmd_sel_i] <= cmd_wdata_i;
          else
            cmd_err_o <= 1'b1;
          cmd_rdata_o <= cmd_ok ? cmd_wdata_i : pend_ff[cmd_sel_i];
        end else begin
          cmd_rdata_o <= pend_ff[cmd_sel_i];
        end
      end
      if (cmd_apply_i) begin
        for (i = 0; i < `IOPM_NUM_SEL; i = i + 1)
          act_ff[i] <= pend_ff[i];
      end
    end
  end

  // pin synchronisers
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sm_sync_ff <= 2'b00;
      slp_sync_ff <= 2'b00;
    end else begin
      sm_sync_ff <= {sm_sync_ff[0], variant_sm_i};
      slp_sync_ff <= {slp_sync_ff[0], sleep_req_i};
    end
  end

  // 100 ms tick and associate blink
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
      blink_cnt_ff <= 32'h00000000;
      blink_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == TICK_CYC - 1);
      tick_cnt_ff <= (tick_cnt_ff == TICK_CYC - 1) ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
      if (blink_cnt_ff == BLINK_CYC - 1) begin
        blink_cnt_ff <= 32'h00000000;
        blink_ff <= ~blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
      end
    end
  end

  // line drive decode
  reg [5:0] nxt_oe;
  reg [5:0] nxt_out;
  reg [5:0] nxt_din;
  reg [3:0] nxt_adc;
  reg [2:0] fn;
  integer k;
  always @* begin
    nxt_oe = 6'h00;
    nxt_out = 6'h00;
    nxt_din = 6'h00;
    nxt_adc = 4'h0;
    fn = 3'h0;
    for (k = 0; k < 6; k = k + 1) begin
      case (k)
        0: fn = fn0;
        1: fn = fn1;
        2: fn = fn2;
        3: fn = fn3;
        4: fn = fn4;
        default: fn = fn5;
      endcase
      case (fn)
        `IOPM_FN_ADC: begin
          if (k < 4)
            nxt_adc[k] = 1'b1;
        end
        `IOPM_FN_DIN: nxt_din[k] = 1'b1;
        `IOPM_FN_LOW: begin
          nxt_oe[k] = 1'b1;
          nxt_out[k] = 1'b0;
        end
        `IOPM_FN_HIGH: begin
          nxt_oe[k] = 1'b1;
          nxt_out[k] = 1'b1;
        end
        `IOPM_FN_ALT: begin
          if (k == 1 && is_th) begin
            nxt_oe[k] = 1'b1;
            nxt_out[k] = attn_i;
          end else if (k == 5) begin
            nxt_oe[k] = 1'b1;
            nxt_out[k] = assoc_i & blink_ff;
          end else if (k >= 2 && k <= 4 && is_th) begin
            nxt_din[k] = 1'b1;
          end
        end
        default: begin
          nxt_oe[k] = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      line_oe_o <= 6'h00;
      line_out_o <= 6'h00;
      line_din_en_o <= 6'h00;
      line_adc_en_o <= 4'h0;
      sleep_din_en_o <= 1'b0;
      pin_sleep_o <= 1'b0;
      spi_miso_en_o <= 1'b0;
      spi_mosi_en_o <= 1'b0;
      spi_ssel_en_o <= 1'b0;
      spi_sclk_en_o <= 1'b0;
      serial_attention_out_en_o <= 1'b0;
      pull_en_o <= 8'hff;
      pull_up_o <= 8'hff;
    end else begin
      line_oe_o <= nxt_oe;
      line_out_o <= nxt_out;
      line_din_en_o <= nxt_din;
      line_adc_en_o <= nxt_adc;
      sleep_din_en_o <= (fn_slp == `IOPM_FN_DIN);
      pin_sleep_o <= slp_sync_ff[1];
      spi_miso_en_o <= is_th ? act_ff[`IOPM_SEL_MISO_TH][0] : act_ff[`IOPM_SEL_MISO_SM][0];
      spi_mosi_en_o <= is_th ? (fn4 == `IOPM_FN_ALT) : act_ff[`IOPM_SEL_MOSI_SM][0];
      spi_ssel_en_o <= is_th ? (fn3 == `IOPM_FN_ALT) : act_ff[`IOPM_SEL_SSEL_SM][0];
      spi_sclk_en_o <= is_th ? (fn2 == `IOPM_FN_ALT) : act_ff[`IOPM_SEL_SCLK_SM][0];
      serial_attention_out_en_o <= is_th ? (fn1 == `IOPM_FN_ALT) : act_ff[`IOPM_SEL_ATTN_SM][0];
      pull_en_o <= act_ff[`IOPM_SEL_PULL_EN][7:0];
      pull_up_o <= act_ff[`IOPM_SEL_PULL_DIR][7:0];
    end
  end

  wire pass_off = (src_addr == 64'hffffffffffffffff);
  wire src_ok = ~pass_off && ((src_addr == `IOPM_ANY_ADDR) || (src_addr == sample_src_i));
  wire upd0 = sample_valid_i && src_ok && (pfn0 == `IOPM_PWM_PLAIN);
  wire upd1 = sample_valid_i && src_ok && (pfn1 == `IOPM_PWM_PLAIN);
  wire rssi_mode = (pfn0 == `IOPM_PWM_RSSI);

  // live duty, signal-strength and revert timers
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      duty0_ff <= 10'h000;
      duty1_ff <= 10'h000;
      rssi_cnt_ff <= 8'h00;
      rssi_on_ff <= 1'b0;
      rev0_cnt_ff <= 8'h00;
      rev1_cnt_ff <= 8'h00;
    end else if (cmd_apply_i) begin
      duty0_ff <= pend_ff[`IOPM_SEL_DUTY0][9:0];
      duty1_ff <= pend_ff[`IOPM_SEL_DUTY1][9:0];
      rssi_on_ff <= 1'b0;
      rev0_cnt_ff <= 8'h00;
      rev1_cnt_ff <= 8'h00;
    end else begin
      if (rssi_mode && rx_pkt_i) begin
        duty0_ff <= {rx_rssi_i, 2'b11};
        rssi_cnt_ff <= rssi_tmr;
        rssi_on_ff <= (rssi_tmr != 8'h00);
      end else if (rssi_mode && tick_ff && rssi_on_ff && rssi_tmr != `IOPM_TMR_ALWAYS) begin
        rssi_cnt_ff <= rssi_cnt_ff - 8'h01;
        if (rssi_cnt_ff <= 8'h01)
          rssi_on_ff <= 1'b0;
      end else if (upd0) begin
        duty0_ff <= sample_ad0_i;
        rev0_cnt_ff <= pwm_tmo;
      end else if (pfn0 == `IOPM_PWM_PLAIN && tick_ff && rev0_cnt_ff != 8'h00) begin
        rev0_cnt_ff <= rev0_cnt_ff - 8'h01;
        if (rev0_cnt_ff == 8'h01)
          duty0_ff <= cfg_duty0;
      end
      if (upd1) begin
        duty1_ff <= sample_ad0_i;
        rev1_cnt_ff <= pwm_tmo;
      end else if (pfn1 == `IOPM_PWM_PLAIN && tick_ff && rev1_cnt_ff != 8'h00) begin
        rev1_cnt_ff <= rev1_cnt_ff - 8'h01;
        if (rev1_cnt_ff == 8'h01)
          duty1_ff <= cfg_duty1;
      end
    end
  end

  wire [19:0] step_pos = {10'h000, pwm_cnt_ff} * `IOPM_PWM_STEPS;
  wire [19:0] thr0 = {10'h000, duty0_ff} * PWM_CYC[19:0];
  wire [19:0] thr1 = {10'h000, duty1_ff} * PWM_CYC[19:0];
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pwm_cnt_ff <= 10'h000;
      pwm0_o <= 1'b0;
      pwm1_o <= 1'b0;
    end else begin
      pwm_cnt_ff <= (pwm_cnt_ff == PWM_CYC[9:0] - 10'h001) ? 10'h000 : pwm_cnt_ff + 10'h001;
      pwm0_o <= (step_pos < thr0) &&
        ((pfn0 == `IOPM_PWM_PLAIN) || (rssi_mode && rssi_on_ff));
      pwm1_o <= (step_pos < thr1) && (pfn1 == `IOPM_PWM_PLAIN);
    end
  end

endmodule // iopm_core

// ===== core/iopm_regs.vh
`ifndef IOPM_REGS_VH
`define IOPM_REGS_VH
// setting selectors on the command port
`define IOPM_SEL_DIO0 5'h00
`define IOPM_SEL_DIO1 5'h01
`define IOPM_SEL_DIO2 5'h02
`define IOPM_SEL_DIO3 5'h03
`define IOPM_SEL_DIO4 5'h04
`define IOPM_SEL_DIO5 5'h05
`define IOPM_SEL_SLEEP 5'h06
`define IOPM_SEL_PWM0_FN 5'h07
`define IOPM_SEL_PWM1_FN 5'h08
`define IOPM_SEL_MISO_TH 5'h09
`define IOPM_SEL_DUTY0 5'h0a
`define IOPM_SEL_DUTY1 5'h0b
`define IOPM_SEL_MISO_SM 5'h0c
`define IOPM_SEL_MOSI_SM 5'h0d
`define IOPM_SEL_SSEL_SM 5'h0e
`define IOPM_SEL_SCLK_SM 5'h0f
`define IOPM_SEL_ATTN_SM 5'h10
`define IOPM_SEL_PULL_EN 5'h11
`define IOPM_SEL_PULL_DIR 5'h12
`define IOPM_SEL_RSSI_TMR 5'h13
`define IOPM_SEL_PWM_TMO 5'h14
`define IOPM_SEL_ADDR0 5'h15
`define IOPM_SEL_ADDR3 5'h18
`define IOPM_NUM_SEL 25
// reset values
`define IOPM_RST_DIO5 16'h0001
`define IOPM_RST_PWM0_FN 16'h0001
`define IOPM_RST_SM_PIN 16'h0001
`define IOPM_RST_PULL 16'h00ff
`define IOPM_RST_RSSI_TMR 16'h0028
`define IOPM_RST_PWM_TMO 16'h00ff
`define IOPM_RST_ADDR 16'hffff
`define IOPM_RST_ZERO 16'h0000
// line function codes
`define IOPM_FN_OFF 3'h0
`define IOPM_FN_ALT 3'h1
`define IOPM_FN_ADC 3'h2
`define IOPM_FN_DIN 3'h3
`define IOPM_FN_LOW 3'h4
`define IOPM_FN_HIGH 3'h5
// pwm pin codes
`define IOPM_PWM_OFF 2'h0
`define IOPM_PWM_RSSI 2'h1
`define IOPM_PWM_PLAIN 2'h2
// timing
`define IOPM_CLK_NS 100
`define IOPM_PWM_PERIOD_NS 64000
`define IOPM_PWM_STEPS 20'd1023
`define IOPM_TICK_NS 100000000
`define IOPM_BLINK_NS 250000000
`define IOPM_TMR_ALWAYS 8'hff
`define IOPM_ANY_ADDR 64'h000000000000ffff
`endif

// ===== verif/iopm_core_sva.sv
`timescale 1ns/1ps
module iopm_core_sva (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // command port
  input wire cmd_valid_i,
  input wire cmd_write_i,
  input wire [4:0] cmd_sel_i,
  input wire [15:0] cmd_wdata_i,
  input wire cmd_apply_i,
  input wire cmd_ack_o,
  input wire cmd_err_o,
  input wire [15:0] cmd_rdata_o,
  // pins
  input wire sleep_req_i,
  input wire pin_sleep_o,
  input wire [7:0] pull_en_o,
  input wire [7:0] pull_up_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ack_one_cycle: assert property (cmd_valid_i |=> cmd_ack_o) else $error("ack missing after command");
  a_ack_has_cause: assert property (cmd_ack_o |-> $past(cmd_valid_i)) else $error("ack without command");
  a_bad_sel_err: assert property (cmd_valid_i && cmd_sel_i > 5'd24 |=> cmd_err_o && cmd_rdata_o == 16'h0000)
    else $error("bad selector not refused");
  a_line_bad_code: assert property (cmd_valid_i && cmd_write_i && ((cmd_sel_i == 5'h00 && cmd_wdata_i == 16'h0001)
    || ((cmd_sel_i == 5'h04 || cmd_sel_i == 5'h05) && cmd_wdata_i == 16'h0002)) |=> cmd_err_o) else $error("line code taken");
  a_sleep_bad_code: assert property (cmd_valid_i && cmd_write_i && cmd_sel_i == 5'h06
    && cmd_wdata_i != 16'h0000 && cmd_wdata_i != 16'h0003 |=> cmd_err_o) else $error("sleep code taken");
  a_pwm_bad_code: assert property (cmd_valid_i && cmd_write_i && ((cmd_sel_i == 5'h07 && cmd_wdata_i > 16'h0002)
    || (cmd_sel_i == 5'h08 && cmd_wdata_i != 16'h0000 && cmd_wdata_i != 16'h0002)) |=> cmd_err_o) else $error("pwm code taken");
  a_mask_write_ok: assert property (cmd_valid_i && cmd_write_i && cmd_sel_i == 5'h11 && cmd_wdata_i[15:8] == 8'h00
    |=> !cmd_err_o && cmd_rdata_o == $past(cmd_wdata_i)) else $error("mask write wrong");
  a_rdata_holds: assert property (!cmd_ack_o && $past(nrst_i) |-> $stable(cmd_rdata_o)) else $error("read data moved");
  a_sleep_follow: assert property ($rose(sleep_req_i) ##0 sleep_req_i [*4] |-> pin_sleep_o) else $error("sleep not followed");
  a_pull_by_apply: assert property ($changed(pull_en_o) || $changed(pull_up_o) |-> $past(cmd_apply_i, 2))
    else $error("pull changed without apply");
endmodule // iopm_core_sva
bind iopm_core iopm_core_sva u_iopm_core_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i), .cmd_apply_i(cmd_apply_i),
  .cmd_ack_o(cmd_ack_o), .cmd_err_o(cmd_err_o), .cmd_rdata_o(cmd_rdata_o), .sleep_req_i(sleep_req_i),
  .pin_sleep_o(pin_sleep_o), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o));

// ===== verif/iopm_pwm_meter.sv
`timescale 1ns/1ps
module iopm_pwm_meter (
  // clock and window
  input wire sys_clk_i,
  input wire win_i,
  input wire sleep_lvl_i,
  // pins
  input wire pwm0_i,
  input wire pwm1_i,
  output wire sleep_req_o,
  output reg [9:0] hi0_o,
  output reg [9:0] hi1_o
);
  reg win_ff = 1'b0;
  initial hi0_o = 10'h000;
  initial hi1_o = 10'h000;
  assign sleep_req_o = sleep_lvl_i;
  always @(posedge sys_clk_i) begin
    win_ff <= win_i;
    if (win_i && !win_ff) begin
      hi0_o <= {9'h000, pwm0_i};
      hi1_o <= {9'h000, pwm1_i};
    end else if (win_i) begin
      hi0_o <= hi0_o + {9'h000, pwm0_i};
      hi1_o <= hi1_o + {9'h000, pwm1_i};
    end
  end
endmodule // iopm_pwm_meter

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg sys_clk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_apply_i = 1'b0;
  reg [4:0] cmd_sel_i = 5'h00;
  reg [15:0] cmd_wdata_i = 16'h0000;
  reg rx_pkt_i = 1'b0, sample_valid_i = 1'b0, win = 1'b0, sleep_lvl = 1'b0, variant_sm_i = 1'b1;
  reg [7:0] rx_rssi_i = 8'h00;
  reg [63:0] sample_src_i = 64'h0;
  reg [9:0] sample_ad0_i = 10'h000;
  wire cmd_ack_o, cmd_err_o, sleep_req_i, sleep_din_en_o, pin_sleep_o, pwm0_o, pwm1_o;
  wire [15:0] cmd_rdata_o;
  wire [5:0] line_oe_o, line_out_o, line_din_en_o;
  wire [3:0] line_adc_en_o;
  wire [4:0] spi_en;
  wire [7:0] pull_en_o, pull_up_o;
  wire [9:0] hi0, hi1;
  reg [15:0] shadow [0:24];
  reg [16:0] exp_q [$];
  reg [16:0] exp_e;
  reg [15:0] v, r;
  integer err_count = 0, compares = 0, s, k, rnd;
  iopm_core #(.TICK_CYC(20), .BLINK_CYC(8)) u_iopm_core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_apply_i(cmd_apply_i), .cmd_ack_o(cmd_ack_o), .cmd_err_o(cmd_err_o), .cmd_rdata_o(cmd_rdata_o),
    .variant_sm_i(variant_sm_i), .sleep_req_i(sleep_req_i), .assoc_i(1'b1), .attn_i(1'b0), .rx_pkt_i(rx_pkt_i),
    .rx_rssi_i(rx_rssi_i), .sample_valid_i(sample_valid_i), .sample_src_i(sample_src_i),
    .sample_ad0_i(sample_ad0_i), .line_oe_o(line_oe_o), .line_out_o(line_out_o), .line_din_en_o(line_din_en_o),
    .line_adc_en_o(line_adc_en_o), .sleep_din_en_o(sleep_din_en_o), .pin_sleep_o(pin_sleep_o),
    .spi_miso_en_o(spi_en[4]), .spi_mosi_en_o(spi_en[3]), .spi_ssel_en_o(spi_en[2]), .spi_sclk_en_o(spi_en[1]),
    .serial_attention_out_en_o(spi_en[0]), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o), .pwm0_o(pwm0_o), .pwm1_o(pwm1_o));
  iopm_pwm_meter u_iopm_pwm_meter (.sys_clk_i(sys_clk_i), .win_i(win), .sleep_lvl_i(sleep_lvl), .pwm0_i(pwm0_o),
    .pwm1_i(pwm1_o), .sleep_req_o(sleep_req_i), .hi0_o(hi0), .hi1_o(hi1));
  always #50 sys_clk_i = ~sys_clk_i;
  function automatic [15:0] rst_val(input [4:0] a);
    case (a)
      5'h05, 5'h07, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10: rst_val = 16'h0001;
      5'h11, 5'h12, 5'h14: rst_val = 16'h00ff;
      5'h13: rst_val = 16'h0028;
      5'h15, 5'h16, 5'h17, 5'h18: rst_val = 16'hffff;
      default: rst_val = 16'h0000;
    endcase
  endfunction
  function automatic [15:0] fmask(input [4:0] a);
    case (a)
      5'h07, 5'h08: fmask = 16'h0003;
      5'h09, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10: fmask = 16'h0001;
      5'h0a, 5'h0b: fmask = 16'h03ff;
      5'h11, 5'h12, 5'h13, 5'h14: fmask = 16'h00ff;
      default: fmask = (a < 5'h07) ? 16'h0007 : 16'hffff;
    endcase
  endfunction
  function automatic legal(input [4:0] a, input [15:0] d);
    case (a)
      5'h00: legal = d != 16'h1 && d <= 16'h5;
      5'h01, 5'h02, 5'h03: legal = d <= 16'h5;
      5'h04, 5'h05: legal = d != 16'h2 && d <= 16'h5;
      5'h06: legal = d == 16'h0 || d == 16'h3;
      5'h07: legal = d <= 16'h2;
      5'h08: legal = d == 16'h0 || d == 16'h2;
      default: legal = 1'b1;
    endcase
  endfunction
  function automatic [9:0] hiexp(input [9:0] d);
    integer t;
    begin
      t = (d * 640 + 1022) / 1023;
      hiexp = t[9:0];
    end
  endfunction
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        err_count++;
        $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task automatic end_sim;
    begin
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task automatic do_reset(input integer n);
    integer i;
    begin
      for (i = 0; i < 25; i++) shadow[i] = rst_val(i[4:0]);
      nrst_i <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
    end
  endtask
  task automatic cmd(input w, input [4:0] a, input [15:0] d);
    reg [16:0] e;
    begin
      if (a > 5'd24) e = 17'h10000;
      else if (!w) e = {1'b0, shadow[a]};
      else if (legal(a, d)) begin
        shadow[a] = d;
        e = {1'b0, d};
      end else e = {1'b1, shadow[a]};
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_write_i <= w;
      cmd_sel_i <= a;
      cmd_wdata_i <= d;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
    end
  endtask
  task automatic apply;
    begin
      @(posedge sys_clk_i);
      cmd_apply_i <= 1'b1;
      @(posedge sys_clk_i);
      cmd_apply_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
    end
  endtask
  task automatic meas(input [9:0] e0, input [9:0] e1);
    begin
      @(posedge sys_clk_i);
      win <= 1'b1;
      repeat (640) @(posedge sys_clk_i);
      win <= 1'b0;
      #1;
      check("pwm0_high", hi0, e0);
      check("pwm1_high", hi1, e1);
    end
  endtask
  always @(posedge sys_clk_i) begin
    if (nrst_i && cmd_ack_o !== 1'b0) begin
      if (exp_q.size() == 0) check("spurious_ack", 64'h1, 64'h0);
      else begin
        exp_e = exp_q.pop_front();
        check("cmd_answer", {cmd_err_o, cmd_rdata_o}, exp_e);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    err_count++;
    end_sim;
  end
  initial begin
    rnd = $urandom(48273);
    do_reset(12);
    @(posedge sys_clk_i);
    rx_pkt_i <= 1'b1;
    rx_rssi_i <= 8'h7f;
    @(posedge sys_clk_i);
    rx_pkt_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    meas(hiexp(10'h1ff), 10'h000);
    for (s = 0; s < 26; s++) cmd(1'b0, s[4:0], 16'h0000);
    for (s = 0; s < 32; s++) begin
      for (k = 0; k < 8; k++) begin
        v = (k == 7) ? $urandom : ((k == 6) ? 16'hffff : k[15:0]);
        cmd(1'b1, s[4:0], v & fmask(s[4:0]));
      end
    end
    cmd(1'b1, 5'h00, 16'h4);
    cmd(1'b1, 5'h01, 16'h5);
    cmd(1'b1, 5'h02, 16'h3);
    cmd(1'b1, 5'h03, 16'h2);
    cmd(1'b1, 5'h04, 16'h5);
    cmd(1'b1, 5'h05, 16'h0);
    cmd(1'b1, 5'h06, 16'h3);
    cmd(1'b1, 5'h11, 16'h006f);
    r = $urandom & 16'h00ff;
    cmd(1'b1, 5'h12, r);
    v = $urandom & 16'h001f;
    for (k = 0; k < 5; k++) cmd(1'b1, 5'h0c + k[4:0], {15'h0, v[4 - k]});
    apply;
    check("pull_en", pull_en_o, 8'h6f);
    check("pull_up", pull_up_o, r[7:0]);
    check("line_oe", {line_oe_o, line_out_o}, 12'b010011_010010);
    check("line_in", {line_din_en_o, line_adc_en_o, sleep_din_en_o}, 11'b000100_1000_1);
    check("spi_en", spi_en, v[4:0]);
    @(posedge sys_clk_i);
    sleep_lvl <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check("pin_sleep", pin_sleep_o, 1'b1);
    v = $urandom & 16'h03ff;
    cmd(1'b1, 5'h07, 16'h2);
    cmd(1'b1, 5'h08, 16'h2);
    cmd(1'b1, 5'h0a, 16'h03ff);
    cmd(1'b1, 5'h0b, v);
    cmd(1'b1, 5'h14, 16'h0);
    apply;
    meas(10'd640, hiexp(v[9:0]));
    cmd(1'b1, 5'h15, 16'hffff);
    for (k = 0; k < 3; k++) cmd(1'b1, 5'h16 + k[4:0], 16'h0);
    apply;
    v = $urandom & 16'h03ff;
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b1;
    sample_src_i <= {$urandom, $urandom};
    sample_ad0_i <= v[9:0];
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b0;
    meas(hiexp(v[9:0]), hiexp(v[9:0]));
    repeat (3) @(posedge sys_clk_i);
    variant_sm_i <= 1'b0;
    do_reset(2);
    for (s = 17; s < 19; s++) cmd(1'b0, s[4:0], 16'h0000);
    cmd(1'b1, 5'h01, 16'h1);
    cmd(1'b1, 5'h04, 16'h1);
    cmd(1'b1, 5'h09, 16'h1);
    apply;
    check("th_line_oe", line_oe_o, 6'b100010);
    check("th_line_din", line_din_en_o, 6'b010000);
    check("th_spi_en", spi_en, 5'b11001);
    for (k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge sys_clk_i);
    check("queue_left", exp_q.size(), 0);
    end_sim;
  end
endmodule // testbench
